/* File: acr_pkg.sv */
// Constants shared by the attribute controller design files
package acr_pkg;
  // ----------------------------------------------------------------
  // Host I/O port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ACR_PORT_WR = 16'h03C0;
  localparam logic [15:0] ACR_PORT_RD = 16'h03C1;
  localparam logic [15:0] ACR_PORT_STAT_MONO = 16'h03BA;
  localparam logic [15:0] ACR_PORT_STAT_COLOR = 16'h03DA;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] ACR_IDX_PAL_LAST = 5'h0F;
  localparam logic [4:0] ACR_IDX_MODE = 5'h10;
  localparam logic [4:0] ACR_IDX_BORDER = 5'h11;
  localparam logic [4:0] ACR_IDX_PLANE = 5'h12;
  localparam logic [4:0] ACR_IDX_PAN = 5'h13;
  localparam logic [4:0] ACR_IDX_CSEL = 5'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACR_IDX_VIDEN_BIT = 5;
  localparam int ACR_MODE_P54_SEL = 7;
  localparam int ACR_MODE_WIDE = 6;
  localparam int ACR_MODE_PAN_UPPER = 5;
  localparam int ACR_MODE_RSVD = 4;
  localparam int ACR_MODE_BLINK = 3;
  localparam int ACR_MODE_LINE_GFX = 2;
  localparam int ACR_MODE_MONO = 1;
  localparam int ACR_MODE_GRAPHICS = 0;
  localparam int ACR_STAT_VSYNC_BIT = 3;
  localparam int ACR_STAT_IDLE_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] ACR_RST_BYTE = 8'h00;
  localparam logic [5:0] ACR_RST_PAL = 6'h00;
  localparam logic [7:0] ACR_LINE_GFX_LO = 8'hB0;
  localparam logic [7:0] ACR_LINE_GFX_HI = 8'hDF;
  localparam logic [4:0] ACR_BLINK_FRAMES = 5'h10;
  localparam logic [7:0] ACR_BLANK_INDEX = 8'h00;
  typedef enum logic [1:0] {
    ACR_FLIP_INDEX = 2'b01,
    ACR_FLIP_DATA = 2'b10
  } acr_flip_t;
endpackage

/* File: acr_palette_mem.sv */
// Sixteen-entry palette mapping store with two registered read ports
`timescale 1ns/10ps
`default_nettype none
module acr_palette_mem (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [5:0] wr_data,
  input wire logic [3:0] host_addr,
  output logic [5:0] host_data,
  input wire logic [3:0] vid_addr,
  output logic [5:0] vid_data
);
  import acr_pkg::*;
  logic [5:0] mem [16];

  // ----------------------------------------------------------------
  // Storage, one generate entry per palette slot
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_slot
    always_ff @(posedge core_clk) begin
      if (srst) begin
        mem[i] <= ACR_RST_PAL;
      end else if (wr_en && wr_addr == 4'(i)) begin
        mem[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      host_data <= ACR_RST_PAL;
      vid_data <= ACR_RST_PAL;
    end else begin
      host_data <= mem[host_addr];
      vid_data <= mem[vid_addr];
    end
  end
endmodule
`default_nettype wire

/* File: acr_attr_decode.sv */
// Pixel and text attribute decode into a 4-bit colour value
`timescale 1ns/10ps
`default_nettype none
module acr_attr_decode (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] mode,
  input wire logic [3:0] plane_en,
  input wire logic vsync,
  input wire logic pix_valid,
  input wire logic pix_active,
  input wire logic [3:0] plane_data,
  input wire logic [7:0] char_code,
  input wire logic [7:0] attr_byte,
  input wire logic glyph_bit,
  input wire logic glyph_bit8,
  input wire logic ninth_col,
  output logic dec_valid,
  output logic dec_active,
  output logic [3:0] dec_nib,
  output logic [7:0] dec_byte
);
  import acr_pkg::*;
  logic vsync_q;
  logic [4:0] frame_cnt;
  logic blink_on;
  logic half;
  logic [3:0] hi_nib;
  logic fg_on;
  logic line_code;
  logic [3:0] text_nib;
  logic [3:0] next_nib;

  // ----------------------------------------------------------------
  // Blink phase, a divided vertical sync
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vsync_q <= 1'b0;
      frame_cnt <= '0;
      blink_on <= 1'b0;
    end else begin
      vsync_q <= vsync;
      if (vsync && !vsync_q) begin
        if (frame_cnt == ACR_BLINK_FRAMES - 5'h01) begin
          frame_cnt <= '0;
          blink_on <= !blink_on;
        end else begin
          frame_cnt <= frame_cnt + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Colour value
  // ----------------------------------------------------------------
  always_comb begin
    line_code = char_code >= ACR_LINE_GFX_LO &&
                char_code <= ACR_LINE_GFX_HI;
    fg_on = glyph_bit;
    if (ninth_col) begin
      fg_on = mode[ACR_MODE_LINE_GFX] && line_code && glyph_bit8;
    end
    if (mode[ACR_MODE_BLINK] && attr_byte[7] && !blink_on) begin
      fg_on = 1'b0;
    end
    if (mode[ACR_MODE_MONO]) begin
      // Reverse video when the background field is all ones
      if (attr_byte[6:4] == 3'b111) begin
        text_nib = fg_on ? 4'h0 : 4'h7;
      end else begin
        text_nib = fg_on ? {attr_byte[3], 3'b111} : 4'h0;
      end
    end else if (fg_on) begin
      text_nib = attr_byte[3:0];
    end else if (mode[ACR_MODE_BLINK]) begin
      text_nib = {1'b0, attr_byte[6:4]};
    end else begin
      text_nib = attr_byte[7:4];
    end
    next_nib = mode[ACR_MODE_GRAPHICS] ? plane_data : text_nib;
    if (mode[ACR_MODE_GRAPHICS] && mode[ACR_MODE_BLINK] && !blink_on) begin
      next_nib[3] = 1'b0;
    end
    next_nib = next_nib & plane_en;
  end

  // ----------------------------------------------------------------
  // Output stage and nibble pairing for wide mode
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      half <= 1'b0;
      hi_nib <= 4'h0;
      dec_valid <= 1'b0;
      dec_active <= 1'b0;
      dec_nib <= 4'h0;
      dec_byte <= 8'h00;
    end else begin
      dec_valid <= 1'b0;
      if (!pix_active || !mode[ACR_MODE_WIDE]) begin
        half <= 1'b0;
      end
      if (pix_valid) begin
        dec_active <= pix_active;
        dec_nib <= next_nib;
        if (!mode[ACR_MODE_WIDE] || !pix_active) begin
          dec_valid <= 1'b1;
        end else if (!half) begin
          half <= 1'b1;
          hi_nib <= next_nib;
        end else begin
          half <= 1'b0;
          dec_byte <= {hi_nib, next_nib};
          dec_valid <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: acr_top.sv */
// Attribute controller: host port registers and palette index output
// ----------------------------------------------------------------
// Summary of operation
// - Each write to the shared port alternates between index and data.
// - Status register one read returns the toggle to index loading.
// - Data read port returns indexed register, toggle untouched.
// - Reading the shared write port returns the index register.
// - Five index bits select registers 00h-14h; top two read zero.
// - Video enable clear forces displayed pixels to index 00.
// - Palette map registers reachable only while video enable clear.
// - Palette map entries are six bits; upper two read zero.
// - Colour select bits 3:2 give index bits 7:6 for all entries.
// - Mode bit 7 takes index bits 5:4 from colour select 1:0.
// - Mode bit 6 pairs two nibbles, bypassing the palette map.
// - Mode bit 5 restricts panning to the upper split region.
// - Mode bit 3 enables blinking, else attribute bit 7 is intensity in colour decode.
// - Mode bit 2 extends line characters into the ninth column.
// - Mode bit 1 chooses monochrome or colour attribute decode.
// - Mode bit 0 selects text or graphics, matched by software.
// - Border index is driven outside active video.
// - Status mux routes a palette index bit pair to status bits 5:4.
// - Disabled planes contribute zero to the colour value.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module acr_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic misc_color_emul,
  input wire logic vsync,
  input wire logic pix_valid,
  input wire logic pix_active,
  input wire logic pix_upper,
  input wire logic [3:0] plane_data,
  input wire logic [7:0] char_code,
  input wire logic [7:0] attr_byte,
  input wire logic glyph_bit,
  input wire logic glyph_bit8,
  input wire logic ninth_col,
  output logic [7:0] pal_index,
  output logic pal_valid,
  output logic [3:0] pan_shift
);
  import acr_pkg::*;
  acr_flip_t flip;
  logic [4:0] attr_idx;
  logic video_en;
  logic [7:0] mode;
  logic [7:0] border;
  logic [5:0] plane_reg;
  logic [3:0] pan;
  logic [3:0] csel;
  logic [5:0] pal_host;
  logic [5:0] pal_vid;
  logic [1:0] diag;
  logic wr_port;
  logic data_wr;
  logic pal_sel;
  logic pal_wr;
  logic stat_rd;
  logic dec_valid;
  logic dec_active;
  logic [3:0] dec_nib;
  logic [7:0] dec_byte;
  logic s2_valid;
  logic s2_active;
  logic [7:0] s2_byte;
  logic [7:0] next_index;
  logic [7:0] data_read;

  assign wr_port = io_addr == ACR_PORT_WR;
  assign data_wr = io_wr && wr_port && flip == ACR_FLIP_DATA;
  assign pal_sel = attr_idx <= ACR_IDX_PAL_LAST;
  assign pal_wr = data_wr && pal_sel && !video_en;
  assign stat_rd = io_rd && (misc_color_emul ?
                   io_addr == ACR_PORT_STAT_COLOR :
                   io_addr == ACR_PORT_STAT_MONO);

  // ----------------------------------------------------------------
  // Index and data toggle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flip <= ACR_FLIP_INDEX;
    end else if (stat_rd) begin
      flip <= ACR_FLIP_INDEX;
    end else if (io_wr && wr_port) begin
      flip <= flip == ACR_FLIP_INDEX ? ACR_FLIP_DATA : ACR_FLIP_INDEX;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      attr_idx <= '0;
      video_en <= 1'b0;
    end else if (io_wr && wr_port && flip == ACR_FLIP_INDEX) begin
      attr_idx <= io_wdata[4:0];
      video_en <= io_wdata[ACR_IDX_VIDEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= ACR_RST_BYTE;
      border <= ACR_RST_BYTE;
      plane_reg <= ACR_RST_BYTE[5:0];
      pan <= ACR_RST_BYTE[3:0];
      csel <= ACR_RST_BYTE[3:0];
    end else if (data_wr) begin
      // Out-of-range indices fall through and are dropped
      unique case (attr_idx)
        ACR_IDX_MODE: begin
          mode <= io_wdata;
          mode[ACR_MODE_RSVD] <= 1'b0;
        end
        ACR_IDX_BORDER: border <= io_wdata;
        ACR_IDX_PLANE: plane_reg <= io_wdata[5:0];
        ACR_IDX_PAN: pan <= io_wdata[3:0];
        ACR_IDX_CSEL: csel <= io_wdata[3:0];
        default: ;
      endcase
    end
  end

  acr_palette_mem u_mem (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(pal_wr),
    .wr_addr(attr_idx[3:0]),
    .wr_data(io_wdata[5:0]),
    .host_addr(attr_idx[3:0]),
    .host_data(pal_host),
    .vid_addr(dec_nib),
    .vid_data(pal_vid)
  );

  // ----------------------------------------------------------------
  // Host reads
  // ----------------------------------------------------------------
  always_comb begin
    data_read = 8'h00;
    if (pal_sel) begin
      data_read = video_en ? 8'h00 : {2'b00, pal_host};
    end else begin
      unique case (attr_idx)
        ACR_IDX_MODE: data_read = mode;
        ACR_IDX_BORDER: data_read = border;
        ACR_IDX_PLANE: data_read = {2'b00, plane_reg};
        ACR_IDX_PAN: data_read = {4'h0, pan};
        ACR_IDX_CSEL: data_read = {4'h0, csel};
        default: data_read = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_rdata <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= io_rd;
      io_rdata <= 8'h00;
      if (io_rd && wr_port) begin
        io_rdata <= {2'b00, video_en, attr_idx};
      end else if (io_rd && io_addr == ACR_PORT_RD) begin
        io_rdata <= data_read;
      end else if (stat_rd) begin
        io_rdata[5:4] <= diag;
        io_rdata[ACR_STAT_VSYNC_BIT] <= vsync;
        io_rdata[ACR_STAT_IDLE_BIT] <= !pix_active;
      end
    end
  end

  // ----------------------------------------------------------------
  // Video path
  // ----------------------------------------------------------------
  acr_attr_decode u_dec (
    .core_clk(core_clk),
    .srst(srst),
    .mode(mode),
    .plane_en(plane_reg[3:0]),
    .vsync(vsync),
    .pix_valid(pix_valid),
    .pix_active(pix_active),
    .plane_data(plane_data),
    .char_code(char_code),
    .attr_byte(attr_byte),
    .glyph_bit(glyph_bit),
    .glyph_bit8(glyph_bit8),
    .ninth_col(ninth_col),
    .dec_valid(dec_valid),
    .dec_active(dec_active),
    .dec_nib(dec_nib),
    .dec_byte(dec_byte)
  );

  // Match the one-cycle palette lookup
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s2_valid <= 1'b0;
      s2_active <= 1'b0;
      s2_byte <= 8'h00;
    end else begin
      s2_valid <= dec_valid;
      s2_active <= dec_active;
      s2_byte <= dec_byte;
    end
  end

  always_comb begin
    next_index = {csel[3:2], pal_vid};
    if (mode[ACR_MODE_P54_SEL]) begin
      next_index[5:4] = csel[1:0];
    end
    if (mode[ACR_MODE_WIDE]) begin
      next_index = s2_byte;
    end
    if (!s2_active) begin
      next_index = border;
    end else if (!video_en) begin
      next_index = ACR_BLANK_INDEX;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pal_index <= 8'h00;
      pal_valid <= 1'b0;
      diag <= 2'b00;
    end else begin
      pal_valid <= s2_valid;
      if (s2_valid) begin
        pal_index <= next_index;
        unique case (plane_reg[5:4])
          2'b00: diag <= {next_index[2], next_index[0]};
          2'b01: diag <= {next_index[5], next_index[4]};
          2'b10: diag <= {next_index[3], next_index[1]};
          2'b11: diag <= {next_index[7], next_index[6]};
        endcase
      end
    end
  end

  // Lower split region stays unpanned when restricted
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pan_shift <= 4'h0;
    end else begin
      pan_shift <= (mode[ACR_MODE_PAN_UPPER] && !pix_upper) ?
                   4'h0 : pan;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  toggle_flip_a: assert property (@(posedge core_clk) disable iff (srst)
    io_wr && wr_port && !stat_rd |=> flip != $past(flip))
    else $error("shared port write did not flip toggle");
  status_reset_a: assert property (@(posedge core_clk) disable iff (srst)
    stat_rd |=> flip == ACR_FLIP_INDEX)
    else $error("status read did not reset toggle");
  data_read_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    io_rd && io_addr == ACR_PORT_RD && !io_wr |=> $stable(flip))
    else $error("data port read moved toggle");
  index_read_a: assert property (@(posedge core_clk) disable iff (srst)
    io_rd && wr_port |=> io_rdata[7:6] == 2'b00 &&
    io_rdata[4:0] == $past(attr_idx))
    else $error("index read wrong");
  blank_video_a: assert property (@(posedge core_clk) disable iff (srst)
    s2_valid && s2_active && !video_en ##1 $stable(video_en)
    |-> pal_index == ACR_BLANK_INDEX)
    else $error("video disabled but index not zero");
  pal_locked_a: assert property (@(posedge core_clk) disable iff (srst)
    data_wr && pal_sel && video_en ##1 $stable(attr_idx)
    |=> $stable(pal_host))
    else $error("palette written while locked");
  border_out_a: assert property (@(posedge core_clk) disable iff (srst)
    s2_valid && !s2_active |=> pal_index == $past(border))
    else $error("border index not driven");
  pal_upper_a: assert property (@(posedge core_clk) disable iff (srst)
    io_rdata_valid && $past(io_addr) == ACR_PORT_RD &&
    $past(pal_sel) |-> io_rdata[7:6] == 2'b00)
    else $error("palette upper bits not zero");
  high_bits_a: assert property (@(posedge core_clk) disable iff (srst)
    s2_valid && s2_active && video_en && !mode[ACR_MODE_WIDE]
    |=> pal_index[7:6] == $past(csel[3:2]))
    else $error("top index bits not from colour select");
  unmapped_a: assert property (@(posedge core_clk) disable iff (srst)
    io_rd && io_addr == ACR_PORT_RD && attr_idx > ACR_IDX_CSEL
    |=> io_rdata == 8'h00)
    else $error("unmapped index read not zero");
  pair_cov: cover property (@(posedge core_clk)
    mode[ACR_MODE_WIDE] && s2_valid && s2_active);
  idx_data_cov: cover property (@(posedge core_clk)
    io_wr && wr_port ##[1:4] data_wr);
  stat_cov: cover property (@(posedge core_clk) stat_rd);
endmodule
`default_nettype wire

/* File: acr_host_model.sv */
// Host CPU model issuing legacy I/O port cycles to the attribute block
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
  input wire logic core_clk,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid
);
  import acr_pkg::*;
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // --------------------------------------------------------------
  // Port cycles
  // --------------------------------------------------------------
  // Idle bus shows the inverse, so a stale address never decodes
  task automatic put(input logic [15:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = ~w;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask
  // Answer is one cycle after the strobe and stands for that cycle only
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic ok);
    put(a, 8'h00, 1'b0);
    ok = io_rdata_valid;
    d = io_rdata;
  endtask
  // Status read puts the shared port back to index loading
  task automatic sync(input logic color, output logic [7:0] d);
    logic ok;
    rd(color ? ACR_PORT_STAT_COLOR : ACR_PORT_STAT_MONO, d, ok);
  endtask
endmodule
`default_nettype wire

/* File: vga_attribute_controller_tb_top.sv */
// Self-checking bench for the attribute controller
`timescale 1ns/10ps
`default_nettype none
module vga_attribute_controller_tb_top;
  import acr_pkg::*;
  logic core_clk, srst, io_wr, io_rd, io_rdata_valid, misc_color_emul;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, pal_index, d, char_code, attr_byte;
  logic vsync, pix_valid, pix_active, pix_upper, glyph_bit, glyph_bit8;
  logic ninth_col, pal_valid, ok;
  logic [3:0] plane_data, pan_shift;
  int n_errors, tests_run, cyc;
  // Rows: index, data written, value read back
  localparam logic [23:0] ROWS [9] = '{24'h05FF3F, 24'h10FFEF,
    24'h11AAAA, 24'h12FF3F, 24'h13FF0F, 24'h14FF0F, 24'h155500,
    24'h1F5500, 24'h0F2A2A};
  acr_top u_acr_top (.core_clk(core_clk), .srst(srst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .misc_color_emul(misc_color_emul), .vsync(vsync),
    .pix_valid(pix_valid), .pix_active(pix_active),
    .pix_upper(pix_upper), .plane_data(plane_data),
    .char_code(char_code), .attr_byte(attr_byte), .glyph_bit(glyph_bit),
    .glyph_bit8(glyph_bit8), .ninth_col(ninth_col),
    .pal_index(pal_index), .pal_valid(pal_valid), .pan_shift(pan_shift));
  acr_host_model u_acr_host_model (.core_clk(core_clk), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    u_acr_host_model.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask
  task automatic wpair(input logic [7:0] idx, input logic [7:0] val);
    u_acr_host_model.wr(ACR_PORT_WR, idx);
    u_acr_host_model.wr(ACR_PORT_WR, val);
  endtask
  // Dots in (planes 5 then A), then the index three cycles after the last
  task automatic px(input logic act, input int dots, input logic [7:0] exp);
    for (int j = 0; j < dots; j++) begin
      @(posedge core_clk);
      #1;
      pix_valid = 1'b1;
      pix_active = act;
      plane_data = j == 0 ? 4'h5 : 4'hA;
    end
    @(posedge core_clk);
    #1;
    pix_valid = 1'b0;
    for (int k = 0; k < 6 && pal_valid !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk({7'h00, pal_valid}, 8'h01);
    chk(pal_index, exp);
  endtask
  task automatic test_done;
    $display("Counts: %0d checks, %0d errors", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Clock and timeout
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    {srst, misc_color_emul, vsync, pix_valid, pix_active} = 5'b11000;
    {pix_upper, glyph_bit, glyph_bit8, ninth_col} = 4'h0;
    {char_code, attr_byte, plane_data} = 20'h00000;
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk(pal_index, 8'h00);
    rdc(ACR_PORT_WR, 8'h00);
    $display("Test reset done");
    foreach (ROWS[i]) begin
      wpair(ROWS[i][23:16], ROWS[i][15:8]);
      rdc(ACR_PORT_RD, ROWS[i][7:0]);
    end
    $display("Test register table done");
    // Enable set blocks palette access; top index bits read zero
    u_acr_host_model.wr(ACR_PORT_WR, 8'hE5);
    rdc(ACR_PORT_WR, 8'h25);
    u_acr_host_model.wr(ACR_PORT_WR, 8'h00);
    rdc(ACR_PORT_RD, 8'h00);
    u_acr_host_model.wr(ACR_PORT_WR, 8'h05);
    rdc(ACR_PORT_RD, 8'h3F);
    $display("Test video enable access done");
    // Toggle now at data; status read must return it to index
    u_acr_host_model.sync(1'b1, d);
    wpair(8'h11, 8'h5A);
    rdc(ACR_PORT_RD, 8'h5A);
    u_acr_host_model.wr(ACR_PORT_WR, 8'h12);
    rdc(ACR_PORT_RD, 8'h3F);
    u_acr_host_model.wr(ACR_PORT_WR, 8'h0F);
    rdc(ACR_PORT_RD, 8'h0F);
    misc_color_emul = 1'b0;
    u_acr_host_model.wr(ACR_PORT_WR, 8'h11);
    u_acr_host_model.sync(1'b0, d);
    wpair(8'h11, 8'h66);
    rdc(ACR_PORT_RD, 8'h66);
    $display("Test toggle done");
    // Graphics mode matches the graphics controller setting
    wpair(8'h05, 8'h2A);
    wpair(8'h10, 8'h01);
    wpair(8'h14, 8'h0C);
    wpair(8'h12, 8'h3F);
    u_acr_host_model.wr(ACR_PORT_WR, 8'h30);
    px(1'b0, 1, 8'h66);
    px(1'b1, 1, 8'hEA);
    rdc(ACR_PORT_STAT_MONO, 8'h30);
    wpair(8'h30, 8'h81);
    px(1'b1, 1, 8'hCA);
    u_acr_host_model.wr(ACR_PORT_WR, 8'h10);
    px(1'b1, 1, 8'h00);
    $display("Test video path done");
    // Toggle is at data: this lands in mode, panning upper region only
    u_acr_host_model.wr(ACR_PORT_WR, 8'h20);
    @(posedge core_clk);
    #1;
    chk({4'h0, pan_shift}, 8'h00);
    pix_upper = 1'b1;
    @(posedge core_clk);
    #1;
    chk({4'h0, pan_shift}, 8'h0F);
    $display("Test panning done");
    // Text decode: palette 7 = 15h, F = 2Ah, 0 and 8 = 00h
    wpair(8'h07, 8'h15);
    attr_byte = 8'h08;
    glyph_bit = 1'b1;
    wpair(8'h30, 8'h02);
    px(1'b1, 1, 8'hEA);
    ninth_col = 1'b1;
    char_code = 8'hB0;
    glyph_bit8 = 1'b1;
    glyph_bit = 1'b0;
    wpair(8'h30, 8'h06);
    px(1'b1, 1, 8'hEA);
    wpair(8'h30, 8'h02);
    px(1'b1, 1, 8'hC0);
    ninth_col = 1'b0;
    glyph_bit = 1'b1;
    attr_byte = 8'hF8;
    wpair(8'h30, 8'h08);
    px(1'b1, 1, 8'hD5);
    wpair(8'h30, 8'h00);
    px(1'b1, 1, 8'hC0);
    $display("Test text decode done");
    // Wide mode pairs two nibbles and skips the palette map
    wpair(8'h30, 8'h41);
    px(1'b1, 2, 8'h5A);
    wpair(8'h32, 8'h33);
    wpair(8'h30, 8'h01);
    px(1'b1, 1, 8'hC0);
    // Monochrome display with the border kept at zero
    wpair(8'h31, 8'h00);
    wpair(8'h30, 8'h02);
    px(1'b0, 1, 8'h00);
    $display("Test wide mode and planes done");
    test_done();
  end
endmodule
`default_nettype wire
